// ### bench/dcc_host_model.sv
// Main controller on the far side of the serial link.
module dcc_host_model
(
  // Link pins driven by the main controller
  output logic sclk,
  output logic cs_n,
  output logic host_bit,
  // Resolved data line
  input wire logic sdio_wire
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle time between bytes; the core needs three system cycles per byte.
  int unsigned gap_ns = 64;

  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    host_bit = 1'b0;
  end

  // The clock stands low outside frames and is only made here, never by the device.
  // While the device talks, our own drive toggles so stale levels cannot pass.
  task automatic shift_byte(input logic [7:0] tx, input logic drive, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      host_bit = drive ? tx[i] : ~host_bit;
      #6;
      rx[i] = sdio_wire;
      sclk = 1'b1;
      #6;
      sclk = 1'b0;
    end
    #(gap_ns);
  endtask

  task automatic frame(input logic [7:0] instr, input int n, input logic [31:0] wdata,
    output logic [31:0] rdata);
    logic [7:0] b;
    rdata = 32'h0;
    cs_n = 1'b0;
    #12;
    shift_byte(instr, 1'b1, b);
    for (int k = 0; k < n; k++)
    begin
      shift_byte(wdata[31 - 8 * k -: 8], ~instr[7], b);
      rdata[31 - 8 * k -: 8] = b;
    end
    cs_n = 1'b1;
    #24;
  endtask
endmodule

// ### bench/tb_top.sv
`include "dcc_params.svh"
module tb_top;
  import dcc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int unsigned CAL_N = 64;

  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic cal_cmp = 1'b0;
  logic sclk;
  logic cs_n;
  logic host_bit;
  wire logic sdio_in;
  logic sdio_out;
  logic sdio_oe_n;
  logic mod_bit;
  logic out_connect;
  logic hold_cap_connect;
  logic fast_settle;
  logic enhanced_settle;
  logic cal_busy;
  logic [31:0] rd;
  int n_mismatch = 0;
  int tests_run = 0;
  int cycles = 0;

  // The shared data line: the device sets the level while its enable is active, the host otherwise.
  assign sdio_in = sdio_oe_n ? host_bit : sdio_out;

  dcc_core #(.CAL_CYCLES(CAL_N)) u_dut
  (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .sclk(sclk),
    .cs_n(cs_n),
    .sdio_in(sdio_in),
    .sdio_out(sdio_out),
    .sdio_oe_n(sdio_oe_n),
    .cal_cmp(cal_cmp),
    .mod_bit(mod_bit),
    .out_connect(out_connect),
    .hold_cap_connect(hold_cap_connect),
    .fast_settle(fast_settle),
    .enhanced_settle(enhanced_settle),
    .cal_busy(cal_busy)
  );

  dcc_host_model u_host
  (
    .sclk(sclk),
    .cs_n(cs_n),
    .host_bit(host_bit),
    .sdio_wire(sdio_in)
  );

  initial
  begin
    forever #4 sys_clk = ~sys_clk;
  end

  task automatic conclude;
    $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  always @(posedge sys_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      n_mismatch++;
      conclude();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [1:0] cnt, input logic [31:0] d);
    logic [31:0] unused;
    u_host.frame({1'b0, cnt, 1'b0, a}, int'(cnt) + 1, d, unused);
  endtask

  task automatic rdr(input logic [3:0] a, input logic [1:0] cnt);
    u_host.frame({1'b1, cnt, 1'b0, a}, int'(cnt) + 1, 32'h0, rd);
  endtask

  task automatic t_reset;
    rdr(`DCC_ADDR_CMD1, 2'h1);
    check({16'h0, rd[31:16]}, 32'h0000_0800);
    rdr(`DCC_ADDR_OFS2, 2'h2);
    check({8'h0, rd[31:8]}, 32'h0);
    rdr(`DCC_ADDR_GAIN2, 2'h2);
    check({8'h0, rd[31:8]}, 32'h0080_0000);
    check({30'h0, hold_cap_connect, cal_busy}, 32'h0);
  endtask

  task automatic t_data;
    u_host.gap_ns = 200;
    wr(`DCC_ADDR_DATA2, 2'h2, 32'h1234_5600);
    u_host.gap_ns = 64;
    rdr(`DCC_ADDR_DATA2, 2'h2);
    check({8'h0, rd[31:8]}, 32'h0012_3456);
    wr(`DCC_ADDR_CMD0, 2'h0, 32'h4000_0000);
    wr(`DCC_ADDR_CMD0, 2'h0, 32'h0100_0000);
    repeat (10) @(negedge sys_clk);
    check({31'h0, cal_busy}, 32'h0);
    wr(`DCC_ADDR_CMD0, 2'h0, 32'h0);
    rdr(`DCC_ADDR_DATA2, 2'h2);
    check({8'h0, rd[31:8]}, 32'h0);
    wr(`DCC_ADDR_CMD1, 2'h0, 32'h2800_0000);
    check({31'h0, hold_cap_connect}, 32'h1);
  endtask

  task automatic t_settle;
    wr(`DCC_ADDR_CMD1, 2'h0, 32'hA800_0000);
    wr(`DCC_ADDR_CMD0, 2'h0, 32'h9000_0000);
    check({31'h0, fast_settle}, 32'h0);
    check({31'h0, enhanced_settle}, 32'h1);
    wr(`DCC_ADDR_CMD0, 2'h0, 32'h0);
    check({31'h0, enhanced_settle}, 32'h0);
    wr(`DCC_ADDR_CMD1, 2'h0, 32'h2800_0000);
    check({31'h0, fast_settle}, 32'h1);
  endtask

  task automatic t_calrst;
    wr(`DCC_ADDR_OFS2, 2'h2, 32'h0000_1100);
    wr(`DCC_ADDR_GAIN2, 2'h2, 32'h7FFF_F000);
    rdr(`DCC_ADDR_OFS2, 2'h2);
    check({8'h0, rd[31:8]}, 32'h0000_0011);
    wr(`DCC_ADDR_CMD1, 2'h0, 32'h2A00_0000);
    wr(`DCC_ADDR_CMD1, 2'h0, 32'h2800_0000);
    rdr(`DCC_ADDR_OFS2, 2'h2);
    check({8'h0, rd[31:8]}, 32'h0);
    rdr(`DCC_ADDR_GAIN2, 2'h2);
    check({8'h0, rd[31:8]}, 32'h0);
  endtask

  // A write lands during the run to prove that the bank is locked meanwhile.
  task automatic t_cal(input logic pin, input logic cmp, input logic [23:0] ofs,
    input logic [23:0] gain);
    int n;
    logic ok;
    ok = 1'b1;
    n = 0;
    @(posedge sys_clk);
    cal_cmp <= cmp;
    wr(`DCC_ADDR_CMD1, 2'h0, {1'b0, pin, 6'h28, 24'h0});
    fork
      begin
        wr(`DCC_ADDR_CMD0, 2'h0, 32'h0100_0000);
        wr(`DCC_ADDR_DATA0, 2'h0, 32'hAA00_0000);
      end
      begin
        repeat (16) @(negedge sclk);
        while (cal_busy !== 1'b1 && n < 20)
        begin
          @(negedge sys_clk);
          n++;
        end
        check({31'h0, n <= 6}, 32'h1);
        n = 0;
        while (cal_busy === 1'b1 && n < 200)
        begin
          if (out_connect !== pin)
            ok = 1'b0;
          @(negedge sys_clk);
          n++;
        end
        check({31'h0, ok}, 32'h1);
        check({31'h0, n >= CAL_N - 1 && n <= CAL_N + 1}, 32'h1);
      end
    join
    rdr(`DCC_ADDR_CMD0, 2'h0);
    check({30'h0, rd[25:24]}, 32'h0);
    rdr(`DCC_ADDR_DATA0, 2'h0);
    check({24'h0, rd[31:24]}, 32'h0);
    rdr(`DCC_ADDR_OFS2, 2'h2);
    check({8'h0, rd[31:8]}, {8'h0, ofs});
    rdr(`DCC_ADDR_GAIN2, 2'h2);
    check({8'h0, rd[31:8]}, {8'h0, gain});
  endtask

  initial
  begin
    repeat (3) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    t_reset();
    t_data();
    t_settle();
    t_calrst();
    t_cal(1'b0, 1'b1, 24'h000008, 24'h800100);
    t_cal(1'b1, 1'b0, 24'hFFFFF8, 24'h800000);
    conclude();
  end
endmodule

// ### common/dcc_params.svh
`ifndef DCC_PARAMS_SVH
`define DCC_PARAMS_SVH
// Register addresses carried in the instruction byte.
`define DCC_ADDR_DATA2 4'h0
`define DCC_ADDR_DATA1 4'h1
`define DCC_ADDR_DATA0 4'h2
`define DCC_ADDR_CMD1 4'h4
`define DCC_ADDR_CMD0 4'h5
`define DCC_ADDR_OFS2 4'h8
`define DCC_ADDR_OFS1 4'h9
`define DCC_ADDR_OFS0 4'hA
`define DCC_ADDR_GAIN2 4'hC
`define DCC_ADDR_GAIN1 4'hD
`define DCC_ADDR_GAIN0 4'hE
// Instruction byte fields.
`define DCC_INS_RW 7
`define DCC_INS_CNT_HI 6
`define DCC_INS_CNT_LO 5
// Command register fields.
`define DCC_CMD_ADAPT 15
`define DCC_CMD_CAL_OUTPUT_CONNECT 14
`define DCC_CMD_HOLD 13
`define DCC_CMD_CALRST 9
`define DCC_CMD_RES 7
`define DCC_CMD_CLR 6
`define DCC_CMD_FMT 5
`define DCC_CMD_SETTLE 4
`define DCC_CMD_MODE_HI 1
`define DCC_CMD_MODE_LO 0
// Reset value, fixed-bit mask and mode codes.
`define DCC_CMD_RESET 16'h0800
`define DCC_CMD_FIXED_MASK 16'h1C00
`define DCC_MODE_NORMAL 2'h0
`define DCC_MODE_SELFCAL 2'h1
// Calibration timing and modulator divider.
`define DCC_CLK_MHZ 125
`define DCC_CAL_MIN_MS 300
`define DCC_CAL_MAX_MS 500
`define DCC_CAL_CYCLES (`DCC_CAL_MIN_MS * 1000 * `DCC_CLK_MHZ)
`define DCC_CAL_AVG_LOG2 4
`define DCC_MOD_DIV 8
`endif

// ### common/dcc_pkg.sv
package dcc_pkg;
  typedef enum logic [2:0]
  {
    DCC_POR = 3'h1,
    DCC_CAL = 3'h2,
    DCC_RUN = 3'h4
  } dcc_ctl_type;

  typedef struct packed
  {
    logic [3:0] addr;
    logic [7:0] data;
  } dcc_wr_type;

  typedef struct packed
  {
    logic [7:0] shift;
    logic [2:0] bits;
    logic header;
    logic rd;
    logic [1:0] left;
    logic [3:0] addr;
    logic tog;
    logic [3:0] wr_addr;
    logic [7:0] wr_data;
    logic sdo;
    logic sdo_oe_n;
  } dcc_link_type;
endpackage

// ### verilog/dcc_core.sv
`include "dcc_params.svh"
// Behaviour
// - Self-cal starts on mode 01 with hold set.
// - Calibration begins on the next clock.
// - Calibration first clears the offset register.
// - Offset result averaged, stored two's complement.
// - Gain result stored as plain code.
// - Calibration lasts 300 to 500 ms; the core runs CAL_CYCLES clocks, 300 ms at 125 MHz.
// - Serial writes ignored while calibrating.
// - Mode field returns to 00 when done.
// - Output connected in calibration only if pin bit.
// - Resolution bit picks 24 or 20 bits.
// - Clear bit zeroes the data input register.
// - Cleared output: 0 V unipolar, reference bipolar.
// - Settling depends on filter, resolution, adaptive bits.
// - Adaptive filter lets step size pick fast.
// - Hold bit clear disconnects second capacitor.
// - Calibration reset bit zeroes both correction registers.
// - Controller has reset, calibrate, run states.
// - Reset state loads every register default.
// - Instruction register cannot be read.
// - Conversion value corrected by offset and gain.
// - Instruction: rw, byte count, start address.
// - Each following byte hits the next address.
// - Command changes land on the third system clock after the last-bit falling edge.
module dcc_core
  import dcc_pkg::*;
#(
  parameter int unsigned CAL_CYCLES = `DCC_CAL_CYCLES
)
(
  // System
  input wire logic sys_clk,
  input wire logic reset_n,
  // Serial link, clocked by the main controller
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdio_in,
  output logic sdio_out,
  output logic sdio_oe_n,
  // Calibration comparator from the analog section
  input wire logic cal_cmp,
  // Analog control
  output logic mod_bit,
  output logic out_connect,
  output logic hold_cap_connect,
  output logic fast_settle,
  output logic enhanced_settle,
  output logic cal_busy
);
  typedef struct packed
  {
    dcc_ctl_type st;
    logic [2:0] tog_sync;
    logic [23:0] data;
    logic [15:0] cmd;
    logic [23:0] ofs;
    logic [23:0] gain;
    logic [31:0] cnt;
    logic [27:0] acc;
    logic [7:0] prev_hi;
    logic big_step;
  } dcc_core_type;

  dcc_core_type s;
  dcc_core_type next_s;
  logic ser_tog;
  dcc_wr_type ser_wr;
  logic [127:0] bank;
  logic cmp_meta;
  logic cmp_q;
  logic wr_event;
  logic signed [23:0] corrected;
  logic signed [47:0] product;
  logic [23:0] data_res;

  localparam logic [31:0] CAL_LAST = 32'(CAL_CYCLES - 1);
  localparam logic [31:0] OFS_END = 32'(CAL_CYCLES / 2);
  localparam logic [31:0] AVG_N = 32'(1 << `DCC_CAL_AVG_LOG2);

  // Read view; the instruction register has no address and so reads nowhere.
  always_comb
  begin
    bank = '0;
    bank[{`DCC_ADDR_DATA2, 3'h0} +: 8] = s.data[23:16];
    bank[{`DCC_ADDR_DATA1, 3'h0} +: 8] = s.data[15:8];
    bank[{`DCC_ADDR_DATA0, 3'h0} +: 8] = s.data[7:0];
    bank[{`DCC_ADDR_CMD1, 3'h0} +: 8] = s.cmd[15:8];
    bank[{`DCC_ADDR_CMD0, 3'h0} +: 8] = s.cmd[7:0];
    bank[{`DCC_ADDR_OFS2, 3'h0} +: 8] = s.ofs[23:16];
    bank[{`DCC_ADDR_OFS1, 3'h0} +: 8] = s.ofs[15:8];
    bank[{`DCC_ADDR_OFS0, 3'h0} +: 8] = s.ofs[7:0];
    bank[{`DCC_ADDR_GAIN2, 3'h0} +: 8] = s.gain[23:16];
    bank[{`DCC_ADDR_GAIN1, 3'h0} +: 8] = s.gain[15:8];
    bank[{`DCC_ADDR_GAIN0, 3'h0} +: 8] = s.gain[7:0];
  end

  dcc_serial u_serial
  (
    .reset_n(reset_n),
    .sclk(sclk),
    .cs_n(cs_n),
    .sdio_in(sdio_in),
    .sdio_out(sdio_out),
    .sdio_oe_n(sdio_oe_n),
    .rd_byte_0(8'h00),
    .rd_base_unused(4'h0),
    .rd_bank(bank),
    .wr_tog(ser_tog),
    .wr_word(ser_wr)
  );

  // The comparator comes from the analog side, so it is synchronised.
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cmp_meta <= 1'b0;
      cmp_q <= 1'b0;
    end
    else
    begin
      cmp_meta <= cal_cmp;
      cmp_q <= cmp_meta;
    end
  end

  // The written byte is stable for a whole link byte after the toggle flips.
  assign wr_event = s.tog_sync[2] ^ s.tog_sync[1];

  // In 20-bit mode the four lowest data bits are ignored.
  assign data_res = s.cmd[`DCC_CMD_RES] ? s.data : {s.data[23:4], 4'h0};

  always_comb
  begin
    product = 48'(signed'(data_res)) * 48'(signed'({1'b0, s.gain[23:1]}));
    corrected = 24'(product >>> 22) + signed'(s.ofs);
  end

  always_comb
  begin
    next_s = s;
    next_s.tog_sync = {s.tog_sync[1:0], ser_tog};
    next_s.prev_hi = s.data[23:16];
    unique case (s.st)
      DCC_POR:
      begin
        next_s.data = '0;
        next_s.cmd = `DCC_CMD_RESET;
        next_s.ofs = '0;
        next_s.gain = 24'h800000;
        next_s.st = DCC_RUN;
      end
      DCC_RUN:
      begin
        if (wr_event)
        begin
          unique case (s.tog_sync[2] ? ser_wr.addr : ser_wr.addr)
            `DCC_ADDR_DATA2: next_s.data[23:16] = ser_wr.data;
            `DCC_ADDR_DATA1: next_s.data[15:8] = ser_wr.data;
            `DCC_ADDR_DATA0: next_s.data[7:0] = ser_wr.data;
            `DCC_ADDR_CMD1: next_s.cmd[15:8] = ser_wr.data;
            `DCC_ADDR_CMD0: next_s.cmd[7:0] = ser_wr.data;
            `DCC_ADDR_OFS2: next_s.ofs[23:16] = ser_wr.data;
            `DCC_ADDR_OFS1: next_s.ofs[15:8] = ser_wr.data;
            `DCC_ADDR_OFS0: next_s.ofs[7:0] = ser_wr.data;
            `DCC_ADDR_GAIN2: next_s.gain[23:16] = ser_wr.data;
            `DCC_ADDR_GAIN1: next_s.gain[15:8] = ser_wr.data;
            `DCC_ADDR_GAIN0: next_s.gain[7:0] = ser_wr.data;
            default: next_s.cmd = s.cmd;
          endcase
        end
        if (s.cmd[`DCC_CMD_CLR])
          next_s.data = '0;
        if (s.cmd[`DCC_CMD_CALRST])
        begin
          next_s.ofs = '0;
          next_s.gain = '0;
        end
        if (s.cmd[`DCC_CMD_MODE_HI:`DCC_CMD_MODE_LO] == `DCC_MODE_SELFCAL
            && s.cmd[`DCC_CMD_HOLD])
        begin
          next_s.st = DCC_CAL;
          next_s.ofs = '0;
          next_s.cnt = '0;
          next_s.acc = '0;
        end
      end
      DCC_CAL:
      begin
        // Serial writes are dropped here, not deferred.
        next_s.cnt = s.cnt + 32'h1;
        if (s.cnt < OFS_END)
        begin
          if (s.cnt < AVG_N)
            next_s.acc = s.acc + (cmp_q ? 28'h1 : 28'h0);
          if (s.cnt == OFS_END - 32'h1)
          begin
            // Count of ones minus half the samples gives a signed offset.
            next_s.ofs = 24'(signed'(s.acc) - signed'(28'(AVG_N >> 1)));
            next_s.acc = '0;
          end
        end
        else
        begin
          if (s.cnt < OFS_END + AVG_N)
            next_s.acc = s.acc + (cmp_q ? 28'h1 : 28'h0);
          if (s.cnt == CAL_LAST)
          begin
            next_s.gain = 24'h800000 + {s.acc[19:0], 4'h0};
            next_s.cmd[`DCC_CMD_MODE_HI:`DCC_CMD_MODE_LO] = `DCC_MODE_NORMAL;
            next_s.st = DCC_RUN;
          end
        end
      end
      default: next_s.st = DCC_POR;
    endcase
    next_s.big_step = (s.data[23:16] != s.prev_hi);
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s <= '0;
      s.st <= DCC_POR;
    end
    else
      s <= next_s;
  end

  dcc_modulator u_mod
  (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .sample(corrected),
    .bit_out(mod_bit)
  );

  // Zero data gives 0 V unipolar or the reference midpoint bipolar.
  assign out_connect = (s.st != DCC_CAL) || s.cmd[`DCC_CMD_CAL_OUTPUT_CONNECT];
  assign hold_cap_connect = s.cmd[`DCC_CMD_HOLD];
  assign enhanced_settle = s.cmd[`DCC_CMD_SETTLE] && s.cmd[`DCC_CMD_RES];
  // A cleared adaptive bit disables adaptive control and always settles fast.
  assign fast_settle = !s.cmd[`DCC_CMD_ADAPT] || s.big_step;
  assign cal_busy = (s.st == DCC_CAL);

  start_next_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (s.st == DCC_RUN && s.cmd[1:0] == 2'h1 && s.cmd[13]) |=> s.st == DCC_CAL)
    else $error("calibration did not start");
  no_start_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (s.st == DCC_RUN && !s.cmd[13]) |=> s.st != DCC_CAL)
    else $error("calibration started without hold bit");
  ofs_clear_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    $rose(cal_busy) |-> s.ofs == 24'h0)
    else $error("offset not cleared");
  mode_done_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    $fell(cal_busy) |-> s.cmd[1:0] == 2'h0)
    else $error("mode not normal after calibration");
  cal_len_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    $fell(cal_busy) |-> $past(s.cnt) == CAL_LAST)
    else $error("calibration length wrong");
  cal_pin_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    cal_busy |-> out_connect == s.cmd[14])
    else $error("output connect wrong in calibration");
  clear_data_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (s.st == DCC_RUN && s.cmd[6]) |=> s.data == 24'h0)
    else $error("data not cleared");
  cal_rst_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (s.st == DCC_RUN && s.cmd[9] && !(s.cmd[1:0] == 2'h1 && s.cmd[13]))
    |=> s.ofs == 24'h0 && s.gain == 24'h0)
    else $error("correction registers not reset");
  cal_lock_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (cal_busy && $past(cal_busy) && s.cnt != 32'h0) |-> $stable(s.data))
    else $error("write accepted during calibration");
  cover_cal: cover property (@(posedge sys_clk) disable iff (!reset_n) $fell(cal_busy));
  cover_write: cover property (@(posedge sys_clk) disable iff (!reset_n) wr_event);
  cover_clear: cover property (@(posedge sys_clk) disable iff (!reset_n) s.cmd[6]);
endmodule

// ### verilog/dcc_modulator.sv
`include "dcc_params.svh"
// Second-order delta-sigma modulator producing the one-bit stream.
module dcc_modulator
  import dcc_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Corrected sample
  input wire logic signed [23:0] sample,
  // Bit stream
  output logic bit_out
);
  typedef struct packed
  {
    logic [2:0] div;
    logic signed [27:0] acc1;
    logic signed [27:0] acc2;
    logic bit_q;
  } dcc_mod_type;
  dcc_mod_type s;
  dcc_mod_type next_s;
  logic signed [27:0] fb;

  always_comb
  begin
    next_s = s;
    fb = s.bit_q ? 28'sh0800000 : -28'sh0800000;
    next_s.div = s.div + 3'h1;
    if (s.div == 3'(`DCC_MOD_DIV - 1))
    begin
      next_s.acc1 = s.acc1 + 28'(sample) - fb;
      next_s.acc2 = s.acc2 + next_s.acc1 - fb;
      next_s.bit_q = ~next_s.acc2[27];
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      s <= '0;
    else
      s <= next_s;
  end

  assign bit_out = s.bit_q;
endmodule

// ### verilog/dcc_serial.sv
`include "dcc_params.svh"
// Serial port on the link clock; finished write bytes cross by toggle.
module dcc_serial
  import dcc_pkg::*;
(
  // Reset from the system side; keeps the write toggle defined
  input wire logic reset_n,
  // Link side
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdio_in,
  output logic sdio_out,
  output logic sdio_oe_n,
  // Read data from the register bank, held stable by the core
  input wire logic [7:0] rd_byte_0,
  input wire logic [3:0] rd_base_unused,
  input wire logic [127:0] rd_bank,
  // Write event toward the core
  output logic wr_tog,
  output dcc_wr_type wr_word
);
  dcc_link_type r;
  dcc_link_type next_r;
  logic unused_in;
  logic wr_tog_hold;
  dcc_wr_type wr_hold;

  assign unused_in = ^{rd_byte_0, rd_base_unused};

  // Rising edge samples data; a byte completes on the falling edge of its last bit.
  logic [7:0] sampled;
  always_ff @(posedge sclk or posedge cs_n)
  begin
    if (cs_n)
      sampled <= 8'h00;
    else
      sampled <= {r.shift[6:0], sdio_in};
  end

  always_comb
  begin
    next_r = r;
    next_r.tog = wr_tog_hold;
    next_r.shift = sampled;
    next_r.bits = r.bits + 3'h1;
    if (r.bits == 3'h7)
    begin
      if (r.header)
      begin
        next_r.header = 1'b0;
        next_r.rd = sampled[`DCC_INS_RW];
        next_r.left = sampled[`DCC_INS_CNT_HI:`DCC_INS_CNT_LO];
        next_r.addr = sampled[3:0];
        if (sampled[`DCC_INS_RW])
          next_r.shift = rd_bank[{sampled[3:0], 3'h0} +: 8];
      end
      else
      begin
        if (!r.rd)
        begin
          next_r.tog = ~wr_tog_hold;
          next_r.wr_addr = r.addr;
          next_r.wr_data = sampled;
        end
        next_r.addr = r.addr + 4'h1;
        next_r.left = r.left - 2'h1;
        if (r.left == 2'h0)
          next_r.header = 1'b1;
        else if (r.rd)
          next_r.shift = rd_bank[{next_r.addr, 3'h0} +: 8];
      end
    end
    next_r.sdo = next_r.shift[7];
    // The enable follows the next state so the first read bit is driven in time.
    next_r.sdo_oe_n = ~(next_r.rd && !next_r.header);
  end

  always_ff @(negedge sclk or posedge cs_n)
  begin
    if (cs_n)
    begin
      r <= '0;
      r.header <= 1'b1;
      r.sdo_oe_n <= 1'b1;
    end
    else
      r <= next_r;
  end

  // Toggle and word survive chip-select so no write event is lost at frame end.
  always_ff @(negedge sclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wr_tog_hold <= 1'b0;
      wr_hold <= '0;
    end
    else
    begin
      wr_tog_hold <= next_r.tog;
      if (next_r.tog != wr_tog_hold)
        wr_hold <= '{addr: next_r.wr_addr, data: next_r.wr_data};
    end
  end

  assign sdio_out = r.sdo;
  assign sdio_oe_n = r.sdo_oe_n;
  assign wr_tog = wr_tog_hold;
  assign wr_word = wr_hold;
endmodule
